/* rtl/alo_pkg.sv */
// Constants and types shared by the add and literal-logic execution unit
package alo_pkg;
  // Datapath and address widths
  localparam int unsigned ALO_DW = 8;
  localparam int unsigned ALO_AW = 12;
  localparam int unsigned ALO_BW = 4;
  localparam int unsigned ALO_FW = 5;
  // Opcode fields: upper byte for literal forms, upper six bits for file forms
  localparam logic [7:0] ALO_OPC_ADD_IMM = 8'h0F;
  localparam logic [7:0] ALO_OPC_AND_IMM = 8'h0B;
  localparam logic [5:0] ALO_OPC_ADD_FILE = 6'h09;
  localparam logic [5:0] ALO_OPC_ADDC_FILE = 6'h08;
  // Instruction bit positions
  localparam int unsigned ALO_BIT_DEST = 9;
  localparam int unsigned ALO_BIT_ACCESS = 8;
  // Addressing constants
  localparam logic [7:0] ALO_INDEXED_MAX = 8'h5F;
  localparam int unsigned ALO_ACC_SPLIT_BIT = 7;
  localparam logic [3:0] ALO_ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ALO_ACC_HI_BANK = 4'hF;
  // Flag positions in the status word
  localparam int unsigned ALO_FLG_C = 0;
  localparam int unsigned ALO_FLG_DIG = 1;
  localparam int unsigned ALO_FLG_Z = 2;
  localparam int unsigned ALO_FLG_OVF = 3;
  localparam int unsigned ALO_FLG_N = 4;
  // Register byte offsets on the bus
  localparam logic [11:0] ALO_OFS_CTRL = 12'h000;
  localparam logic [11:0] ALO_OFS_BANK = 12'h004;
  localparam logic [11:0] ALO_OFS_ACC = 12'h008;
  localparam logic [11:0] ALO_OFS_STATUS = 12'h00C;
  localparam logic [11:0] ALO_OFS_PHASE = 12'h010;
  // Values after reset
  localparam logic [ALO_DW-1:0] ALO_RST_ACC = 8'h00;
  localparam logic [ALO_FW-1:0] ALO_RST_FLAGS = 5'h00;
  localparam logic [ALO_BW-1:0] ALO_RST_BANK = 4'h0;
  localparam logic ALO_RST_EXT = 1'b0;
  // Instruction phases and decoded operation kinds
  typedef enum logic [2:0] {ALO_PH_IDLE, ALO_PH_DECODE, ALO_PH_READ, ALO_PH_PROC, ALO_PH_WRITE} alo_phase_t;
  typedef enum logic [2:0] {ALO_K_NONE, ALO_K_ADD_IMM, ALO_K_AND_IMM, ALO_K_ADD_FILE, ALO_K_ADDC_FILE} alo_kind_t;
endpackage

/* rtl/alo_core.sv */
// Four-phase execution unit for add, add-with-carry and literal AND operations
`timescale 1ns/1ns
// Function
// - Opcode 0010 01da adds the accumulator to the addressed byte and updates all five status flags.
// - With the destination bit at 0 the result goes to the accumulator and the file byte is left alone.
// - With the destination bit at 1 the result is written back to the addressed data-memory byte.
// - With the access bit at 0 the 8-bit file address is resolved inside the fixed access bank.
// - With the access bit at 1 the address is the bank select register joined to the 8-bit file address.
// - Access bit 0, extended mode on and a file address up to 95 select indexed literal offset addressing.
// - Opcode 0010 00da sums accumulator, addressed byte and carry and updates all five status flags.
// - Opcode 0000 1011 ANDs the accumulator with the instruction's low byte and keeps the result there.
// - The AND-immediate operation updates only negative and zero, leaving carry, digit carry and overflow.
// - Opcode 0000 1111 adds the instruction's low byte to the accumulator and updates all five status flags.
module alo_core
  import alo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Instruction from the decoder
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [ALO_AW-1:0] index_base_i,
  output logic instr_ready_o,
  // Banked data memory, read data one cycle after mem_rd_o
  output logic [ALO_AW-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [ALO_DW-1:0] mem_wdata_o,
  input wire logic [ALO_DW-1:0] mem_rdata_i,
  // Architectural state view
  output logic [ALO_DW-1:0] accumulator_o,
  output logic [ALO_FW-1:0] flags_o,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  alo_phase_t phase_reg, phase_next;
  alo_kind_t kind_reg, kind_next, dec_kind;
  logic [15:0] ir_reg, ir_next;
  logic [ALO_DW-1:0] acc_reg, acc_next, result_reg, result_next, wdata_reg, wdata_next, operand, and8;
  logic [ALO_FW-1:0] flags_reg, flags_next, calc_reg, calc_next;
  logic [ALO_BW-1:0] bank_reg, bank_next;
  logic [ALO_AW-1:0] addr_reg, addr_next, dec_addr;
  logic ext_reg, ext_next, ready_reg, ready_next, rd_reg, rd_next, wr_reg, wr_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next, apb_wr, file_op, cin, addr_hit;
  logic [31:0] prdata_reg, prdata_next;
  logic [8:0] sum9;
  logic [4:0] lo5;
  // A write lands only in the completing access cycle
  assign apb_wr = psel && penable && pready_reg && pwrite;
  assign file_op = (kind_reg == ALO_K_ADD_FILE) || (kind_reg == ALO_K_ADDC_FILE);

  // Decode and address formation, evaluated on the held instruction word
  always_comb
  begin
    dec_kind = ALO_K_NONE;
    if (ir_reg[15:8] == ALO_OPC_ADD_IMM) dec_kind = ALO_K_ADD_IMM;
    else if (ir_reg[15:8] == ALO_OPC_AND_IMM) dec_kind = ALO_K_AND_IMM;
    else if (ir_reg[15:10] == ALO_OPC_ADD_FILE) dec_kind = ALO_K_ADD_FILE;
    else if (ir_reg[15:10] == ALO_OPC_ADDC_FILE) dec_kind = ALO_K_ADDC_FILE;
    if (ir_reg[ALO_BIT_ACCESS])
      dec_addr = {bank_reg, ir_reg[7:0]};
    else if (ext_reg && ir_reg[7:0] <= ALO_INDEXED_MAX)
      dec_addr = index_base_i + {4'h0, ir_reg[7:0]};
    else
      dec_addr = {ir_reg[ALO_ACC_SPLIT_BIT] ? ALO_ACC_HI_BANK : ALO_ACC_LO_BANK, ir_reg[7:0]};
  end
  // Arithmetic: memory data arrives in the processing phase; literal comes from the low byte
  always_comb
  begin
    operand = file_op ? mem_rdata_i : ir_reg[7:0];
    cin = (kind_reg == ALO_K_ADDC_FILE) ? flags_reg[ALO_FLG_C] : 1'b0;
    sum9 = {1'b0, acc_reg} + {1'b0, operand} + {8'h00, cin};
    lo5 = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
    and8 = acc_reg & operand;
  end
  // Phase machine, destination handling and software-visible registers
  always_comb
  begin
    phase_next = phase_reg;
    kind_next = kind_reg;
    ir_next = ir_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    calc_next = calc_reg;
    result_next = result_reg;
    bank_next = bank_reg;
    ext_next = ext_reg;
    addr_next = addr_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    wdata_next = wdata_reg;
    // Software writes first so that the core's own update below wins a collision
    if (apb_wr)
    begin
      case (paddr)
        ALO_OFS_CTRL: ext_next = pwdata[0];
        ALO_OFS_BANK: bank_next = pwdata[ALO_BW-1:0];
        ALO_OFS_ACC: acc_next = pwdata[ALO_DW-1:0];
        ALO_OFS_STATUS: flags_next = pwdata[ALO_FW-1:0];
        default: ;
      endcase
    end
    case (phase_reg)
      ALO_PH_IDLE:
      begin
        if (instr_valid_i)
        begin
          ir_next = instr_i;
          phase_next = ALO_PH_DECODE;
        end
      end
      ALO_PH_DECODE:
      begin
        kind_next = dec_kind;
        addr_next = dec_addr;
        rd_next = (dec_kind == ALO_K_ADD_FILE) || (dec_kind == ALO_K_ADDC_FILE);
        phase_next = ALO_PH_READ;
      end
      ALO_PH_READ: phase_next = ALO_PH_PROC;
      ALO_PH_PROC:
      begin
        if (kind_reg == ALO_K_AND_IMM)
          result_next = and8;
        else
          result_next = sum9[7:0];
        calc_next[ALO_FLG_C] = sum9[8];
        calc_next[ALO_FLG_DIG] = lo5[4];
        calc_next[ALO_FLG_OVF] = (acc_reg[7] == operand[7]) && (sum9[7] != acc_reg[7]);
        calc_next[ALO_FLG_N] = (kind_reg == ALO_K_AND_IMM) ? and8[7] : sum9[7];
        calc_next[ALO_FLG_Z] = (kind_reg == ALO_K_AND_IMM) ? (and8 == 8'h00) : (sum9[7:0] == 8'h00);
        wr_next = file_op && ir_reg[ALO_BIT_DEST];
        wdata_next = (kind_reg == ALO_K_AND_IMM) ? and8 : sum9[7:0];
        phase_next = ALO_PH_WRITE;
      end
      ALO_PH_WRITE:
      begin
        // Literal forms and file forms with the destination bit clear land in the accumulator
        if ((kind_reg == ALO_K_ADD_IMM) || (kind_reg == ALO_K_AND_IMM) || (file_op && !ir_reg[ALO_BIT_DEST]))
          acc_next = result_reg;
        if (kind_reg == ALO_K_AND_IMM)
        begin
          flags_next[ALO_FLG_N] = calc_reg[ALO_FLG_N];
          flags_next[ALO_FLG_Z] = calc_reg[ALO_FLG_Z];
        end
        else if (kind_reg != ALO_K_NONE)
          flags_next = calc_reg;
        // Back-to-back issue: the next word is taken while this one writes
        if (instr_valid_i)
        begin
          ir_next = instr_i;
          phase_next = ALO_PH_DECODE;
        end
        else
          phase_next = ALO_PH_IDLE;
      end
      default: phase_next = ALO_PH_IDLE;
    endcase
    ready_next = (phase_next == ALO_PH_IDLE) || (phase_next == ALO_PH_WRITE);
  end
  // State registers of the core
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      phase_reg <= ALO_PH_IDLE;
      kind_reg <= ALO_K_NONE;
      ir_reg <= 16'h0000;
      acc_reg <= ALO_RST_ACC;
      flags_reg <= ALO_RST_FLAGS;
      calc_reg <= ALO_RST_FLAGS;
      result_reg <= 8'h00;
      bank_reg <= ALO_RST_BANK;
      ext_reg <= ALO_RST_EXT;
      ready_reg <= 1'b1;
      addr_reg <= 12'h000;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else
    begin
      phase_reg <= phase_next;
      kind_reg <= kind_next;
      ir_reg <= ir_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      calc_reg <= calc_next;
      result_reg <= result_next;
      bank_reg <= bank_next;
      ext_reg <= ext_next;
      ready_reg <= ready_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
    end
  end
  // APB answer: one wait state, so read data is a registered snapshot
  always_comb
  begin
    pready_next = psel && penable && !pready_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    addr_hit = (paddr == ALO_OFS_CTRL) || (paddr == ALO_OFS_BANK) || (paddr == ALO_OFS_ACC)
      || (paddr == ALO_OFS_STATUS) || (paddr == ALO_OFS_PHASE);
    if (pready_next)
    begin
      pslverr_next = !addr_hit;
      case (paddr)
        ALO_OFS_CTRL: prdata_next = {31'h00000000, ext_reg};
        ALO_OFS_BANK: prdata_next = {28'h0000000, bank_reg};
        ALO_OFS_ACC: prdata_next = {24'h000000, acc_reg};
        ALO_OFS_STATUS: prdata_next = {27'h0000000, flags_reg};
        ALO_OFS_PHASE: prdata_next = {29'h00000000, phase_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end
  // APB response registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end
  // Every output straight from a flip-flop
  assign instr_ready_o = ready_reg;
  assign mem_addr_o = addr_reg;
  assign mem_rd_o = rd_reg;
  assign mem_wr_o = wr_reg;
  assign mem_wdata_o = wdata_reg;
  assign accumulator_o = acc_reg;
  assign flags_o = flags_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  // Checks on the datapath
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_phase_order: assert property (phase_reg == ALO_PH_DECODE |=> phase_reg == ALO_PH_READ ##1
    phase_reg == ALO_PH_PROC ##1 phase_reg == ALO_PH_WRITE)
    else $error("instruction phases out of order");
  chk_file_add: assert property (phase_reg == ALO_PH_PROC && kind_reg == ALO_K_ADD_FILE |=>
    result_reg == 8'($past(acc_reg) + $past(mem_rdata_i)))
    else $error("file add result wrong");
  chk_dest_acc: assert property (phase_reg == ALO_PH_WRITE && file_op && !ir_reg[ALO_BIT_DEST] |->
    !mem_wr_o ##1 acc_reg == $past(result_reg))
    else $error("accumulator destination not honoured");
  chk_dest_file: assert property (phase_reg == ALO_PH_WRITE && file_op && ir_reg[ALO_BIT_DEST] |->
    mem_wr_o && mem_wdata_o == result_reg && mem_addr_o == $past(mem_addr_o, 2))
    else $error("file destination not written");
  chk_access_bank: assert property (phase_reg == ALO_PH_READ && file_op && !ir_reg[ALO_BIT_ACCESS]
    && !($past(ext_reg) && ir_reg[7:0] <= ALO_INDEXED_MAX) |->
    mem_addr_o == {ir_reg[7] ? ALO_ACC_HI_BANK : ALO_ACC_LO_BANK, ir_reg[7:0]} && mem_rd_o)
    else $error("access bank address wrong");
  chk_bank_addr: assert property (phase_reg == ALO_PH_READ && file_op && ir_reg[ALO_BIT_ACCESS] |->
    mem_addr_o == {$past(bank_reg), ir_reg[7:0]})
    else $error("banked address wrong");
  chk_indexed_addr: assert property (phase_reg == ALO_PH_READ && file_op && !ir_reg[ALO_BIT_ACCESS]
    && $past(ext_reg) && ir_reg[7:0] <= ALO_INDEXED_MAX |->
    mem_addr_o == 12'($past(index_base_i) + {4'h0, ir_reg[7:0]}))
    else $error("indexed address wrong");
  chk_carry_add: assert property (phase_reg == ALO_PH_PROC && kind_reg == ALO_K_ADDC_FILE |=>
    {calc_reg[ALO_FLG_C], result_reg} == 9'($past(acc_reg) + $past(mem_rdata_i) + $past(flags_reg[ALO_FLG_C])))
    else $error("carry add wrong");
  chk_and_result: assert property (phase_reg == ALO_PH_PROC && kind_reg == ALO_K_AND_IMM ##1
    phase_reg == ALO_PH_WRITE |=> acc_reg == ($past(acc_reg, 2) & $past(ir_reg[7:0], 2)))
    else $error("literal AND wrong");
  chk_and_flags: assert property (phase_reg == ALO_PH_WRITE && kind_reg == ALO_K_AND_IMM && !apb_wr |=>
    flags_reg[ALO_FLG_C] == $past(flags_reg[ALO_FLG_C]) && flags_reg[ALO_FLG_OVF] == $past(flags_reg[ALO_FLG_OVF])
    && flags_reg[ALO_FLG_DIG] == $past(flags_reg[ALO_FLG_DIG]))
    else $error("literal AND touched carry flags");
  chk_imm_add: assert property (phase_reg == ALO_PH_PROC && kind_reg == ALO_K_ADD_IMM ##1
    phase_reg == ALO_PH_WRITE |=> acc_reg == 8'($past(acc_reg, 2) + $past(ir_reg[7:0], 2)))
    else $error("literal add wrong");
  cov_imm_add: cover property (phase_reg == ALO_PH_WRITE && kind_reg == ALO_K_ADD_IMM);
  cov_file_wb: cover property (phase_reg == ALO_PH_WRITE && file_op && ir_reg[ALO_BIT_DEST]);
  cov_carry_in: cover property (phase_reg == ALO_PH_PROC && kind_reg == ALO_K_ADDC_FILE && cin);
  cov_back2back: cover property (phase_reg == ALO_PH_WRITE && instr_valid_i);

endmodule // alo_core

/* sim/alo_mem_model.sv */
// Behavioural banked data memory facing the execution unit
`timescale 1ns/1ns
module alo_mem_model
  import alo_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Memory port
  input wire logic [ALO_AW-1:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [ALO_DW-1:0] mem_wdata_i,
  output logic [ALO_DW-1:0] mem_rdata_o
);
  logic [ALO_DW-1:0] ram [0:(1<<ALO_AW)-1];
  initial mem_rdata_o = 8'h00;
  // Read data lands one cycle late; outside a read slot the bus toggles so stale data never looks valid
  always @(posedge ref_clk_i)
  begin
    if (mem_rd_i)
      mem_rdata_o <= ram[mem_addr_i];
    else
      mem_rdata_o <= ~mem_rdata_o;
    if (mem_wr_i)
      ram[mem_addr_i] <= mem_wdata_i;
  end
endmodule // alo_mem_model

/* sim/testbench.sv */
// Self-checking bench for the add and literal-logic execution unit
`timescale 1ns/1ns
module testbench;
  import alo_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [11:0] index_base_i = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic instr_ready_o, mem_rd_o, mem_wr_o, pready, pslverr;
  logic [11:0] mem_addr_o, ea;
  logic [7:0] mem_wdata_o, mem_rdata_i, accumulator_o, acc0, k, opnd, exp_acc, exp_mem;
  logic [4:0] flags_o, flg0, exp_flg;
  logic [31:0] prdata, seed = 32'h0000002B, r, q;
  logic [12:0] res;
  logic e, d, a, ext, file_op, wb;
  logic [3:0] bank;
  int n_errors = 0, n_checks = 0, kind, i;
  alo_core uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .index_base_i(index_base_i), .instr_ready_o(instr_ready_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .accumulator_o(accumulator_o),
    .flags_o(flags_o), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  alo_mem_model mem (.ref_clk_i(ref_clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  // Free-running 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected flags and result; the AND form keeps carry, digit carry and overflow
  function automatic logic [12:0] alu(input logic [7:0] x, input logic [7:0] y, input logic ci, input logic land,
    input logic [4:0] f0);
    logic [8:0] s;
    logic [4:0] f;
    f = f0;
    s = land ? {1'b0, x & y} : x + y + ci;
    if (!land)
    begin
      f[ALO_FLG_C] = s[8];
      f[ALO_FLG_DIG] = ({1'b0, x[3:0]} + {1'b0, y[3:0]} + ci) > 5'h0F;
      f[ALO_FLG_OVF] = (x[7] == y[7]) && (s[7] != x[7]);
    end
    f[ALO_FLG_Z] = (s[7:0] == 8'h00);
    f[ALO_FLG_N] = s[7];
    return {f, s[7:0]};
  endfunction
  function automatic logic [11:0] eaddr(input logic [7:0] f, input logic [11:0] ib);
    if (a)
      return {bank, f};
    if (ext && f <= ALO_INDEXED_MAX)
      return ib + {4'h0, f};
    return f[7] ? {ALO_ACC_HI_BANK, f} : {ALO_ACC_LO_BANK, f};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up(input string what);
    check(32'h0, 32'h1, what);
    close_out();
  endtask
  // APB master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    for (n = 0; n < 8 && pready !== 1'b1; n++)
      @(posedge ref_clk_i);
    if (n == 8)
      give_up("bus timeout");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one instruction and follow it through its phases
  task automatic exec(input logic [15:0] w);
    int n;
    logic rd_seen;
    rd_seen = 1'b0;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    for (n = 1; n < 9; n++)
    begin
      @(negedge ref_clk_i);
      if (mem_rd_o === 1'b1)
        rd_seen = 1'b1;
      if (mem_rd_o === 1'b1 && file_op)
        check(mem_addr_o, ea, "address");
      if (instr_ready_o === 1'b1)
        break;
      @(posedge ref_clk_i);
    end
    if (n == 9)
      give_up("instruction timeout");
    check(n, 4, "phase count");
    if (kind != 4)
      check(rd_seen, file_op, "operand read");
    check(mem_wr_o, wb, "write strobe");
    if (wb)
      check(mem_wdata_o, exp_mem, "write data");
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(accumulator_o, exp_acc, "accumulator");
    check(flags_o, exp_flg, "flags");
    check(mem.ram[ea], exp_mem, "memory byte");
  endtask
  // Main sequence: reset, register map, then random and corner instructions
  initial
  begin
    for (i = 0; i < 4096; i++)
      mem.ram[i] = 8'(rnd());
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check(q, 32'h0, "reset value");
      check(e, i == 5, "slave error");
    end
    apb(1'b1, ALO_OFS_PHASE, 32'h00000007);
    apb(1'b0, ALO_OFS_PHASE, 32'h0);
    check(q, 32'h0, "read-only phase");
    for (i = 0; i < 80; i++)
    begin
      r = rnd();
      kind = r[2:0] % 5;
      k = r[15:8];
      d = r[16];
      a = r[17];
      ext = r[18];
      bank = r[23:20];
      acc0 = r[31:24];
      flg0 = 5'(rnd());
      // Hand-picked corners: example sum, wrap to zero, indexed boundary on both sides, upper access bank
      case (i)
        0: {kind, acc0, k} = {32'd0, 8'h10, 8'h15};
        1: {kind, acc0, k} = {32'd0, 8'hFF, 8'h01};
        2: {kind, a, ext, k} = {32'd3, 1'b0, 1'b1, 8'h5F};
        3: {kind, a, ext, k} = {32'd2, 1'b0, 1'b1, 8'h60};
        4: {kind, a, ext, k} = {32'd2, 1'b0, 1'b0, 8'h80};
        5: {kind, acc0, k} = {32'd1, 8'hA3, 8'h5F};
        default: ;
      endcase
      apb(1'b1, ALO_OFS_CTRL, {31'h0, ext});
      apb(1'b1, ALO_OFS_BANK, {28'h0, bank});
      apb(1'b1, ALO_OFS_ACC, {24'h0, acc0});
      apb(1'b1, ALO_OFS_STATUS, {27'h0, flg0});
      apb(1'b0, ALO_OFS_ACC, 32'h0);
      check(q, {24'h0, acc0}, "accumulator readback");
      index_base_i <= 12'(rnd());
      @(posedge ref_clk_i);
      file_op = kind == 2 || kind == 3;
      ea = eaddr(k, index_base_i);
      opnd = file_op ? mem.ram[ea] : k;
      res = alu(acc0, opnd, kind == 3 && flg0[ALO_FLG_C], kind == 1, flg0);
      wb = file_op && d;
      exp_acc = (kind == 4 || wb) ? acc0 : res[7:0];
      exp_flg = kind == 4 ? flg0 : res[12:8];
      exp_mem = file_op ? (wb ? res[7:0] : opnd) : mem.ram[ea];
      case (kind)
        0: exec({ALO_OPC_ADD_IMM, k});
        1: exec({ALO_OPC_AND_IMM, k});
        2: exec({ALO_OPC_ADD_FILE, d, a, k});
        3: exec({ALO_OPC_ADDC_FILE, d, a, k});
        default: exec({8'hFF, k});
      endcase
    end
    // Streamed pair: the second word is taken in the write phase of the first
    acc0 = 8'(rnd());
    flg0 = 5'(rnd());
    k = 8'(rnd());
    opnd = 8'(rnd());
    apb(1'b1, ALO_OFS_ACC, {24'h0, acc0});
    apb(1'b1, ALO_OFS_STATUS, {27'h0, flg0});
    res = alu(acc0, k, 1'b0, 1'b0, flg0);
    res = alu(res[7:0], opnd, 1'b0, 1'b1, res[12:8]);
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= {ALO_OPC_ADD_IMM, k};
    @(posedge ref_clk_i);
    instr_i <= {ALO_OPC_AND_IMM, opnd};
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(instr_ready_o, 1'b1, "ready in write phase");
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check(accumulator_o, res[7:0], "streamed accumulator");
    check(flags_o, res[12:8], "streamed flags");
    // Reset in mid-run brings the accumulator and flags back to their reset values
    apb(1'b1, ALO_OFS_ACC, 32'h000000A5);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, ALO_OFS_ACC, 32'h0);
    check(q, {24'h0, ALO_RST_ACC}, "accumulator after reset");
    check(flags_o, ALO_RST_FLAGS, "flags after reset");
    close_out();
  end
endmodule // testbench
